// *** bench/rtcc_core_test.sv ***
/*
 * rtcc_core_test: self-checking bench of the real time clock core over AHB-Lite.
 * assumes rtcc_pkg and rtcc_core compiled first; timebase counts shortened by parameter.
 */
`timescale 1ns/10ps
module rtcc_core_test;
    import rtcc_pkg::*;

    // ********************************************************
    // types and signals
    // ********************************************************
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] exp;
        logic [7:0] msk;
        logic       chk_irq;
        logic       exp_irq;
    } rtcc_note_s;

    typedef struct packed {
        logic [55:0] init;
        logic [55:0] fin;
        logic [7:0]  ext;
        logic [7:0]  awd;
        logic        af;
    } rtcc_row_s;

    logic          clk;
    logic          srst;
    rtcc_ahb_req_s drv;
    rtcc_ahb_req_s req;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          irq_n;
    logic          rd_dp;
    rtcc_note_s    notes[$];
    rtcc_note_s    cur;
    int            err_total;
    int            n_compared;
    int            cyc;
    logic [31:0]   rnd;
    // fields in order year, month, date, weekday, hours, minutes, seconds
    rtcc_row_s     rows[7] = '{
        '{56'h23_01_31_40_23_59_59, 56'h23_02_01_01_00_00_00, 8'h40, 8'h01, 1'b1},
        '{56'h23_04_30_01_e3_59_59, 56'h23_05_01_02_00_00_00, 8'h00, 8'h02, 1'b1},
        '{56'h23_02_28_02_23_59_59, 56'h23_03_01_04_00_00_00, 8'h00, 8'h02, 1'b0},
        '{56'h24_02_28_04_23_59_59, 56'h24_02_29_08_00_00_00, 8'h40, 8'h01, 1'b0},
        '{56'h24_02_29_08_23_59_59, 56'h24_03_01_10_00_00_00, 8'h40, 8'h01, 1'b1},
        '{56'h99_12_31_10_23_59_59, 56'h00_01_01_20_00_00_00, 8'h40, 8'h81, 1'b1},
        '{56'h01_06_15_20_12_34_09, 56'h01_06_15_20_12_34_10, 8'h00, 8'h20, 1'b0}
    };

    rtcc_core #(.HS_CYCLES_P(4), .T4K_CYCLES_P(3), .T64_CYCLES_P(5)) rtcc_core_inst (
        .clk       (clk),
        .srst      (srst),
        .ahb_req   (req),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .irq_n     (irq_n)
    );

    always_comb begin
        req        = drv;
        req.hready = hreadyout;
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ********************************************************
    // bus tasks, random source, report
    // ********************************************************
    task automatic xfer(input logic [3:0] idx, input logic wr_en, input logic [7:0] d);
        drv.hsel   <= 1'b1;
        drv.htrans <= 2'b10;
        drv.haddr  <= {26'h0, idx, 2'b00};
        drv.hwrite <= wr_en;
        drv.hsize  <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        drv.hsel   <= 1'b0;
        drv.htrans <= 2'b00;
        drv.hwdata <= {24'h0, d};
        rd_dp      <= !wr_en;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp      <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [7:0] e, input logic [7:0] m, input logic ci, input logic ei);
        notes.push_back(rtcc_note_s'{idx, e, m, ci, ei});
        xfer(idx, 1'b0, 8'h00);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ********************************************************
    // output watcher and timeout
    // ********************************************************
    always @(posedge clk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            cur = notes.pop_front();
            n_compared++;
            if ((hrdata & {24'hffffff, cur.msk}) !== {24'h0, cur.exp & cur.msk} || hresp !== 1'b0) begin
                err_total++;
                $display("BAD reg %h exp %h got %h", cur.idx, cur.exp, hrdata);
            end
            if (cur.chk_irq) begin
                n_compared++;
                if (irq_n !== cur.exp_irq) begin
                    err_total++;
                    $display("BAD irq_n exp %b got %b", cur.exp_irq, irq_n);
                end
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            err_total++;
            end_sim();
        end
    end

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        drv        = '0;
        srst       = 1'b1;
        rd_dp      = 1'b0;
        err_total  = 0;
        n_compared = 0;
        cyc        = 0;
        rnd        = 32'd35;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(IDX_WDAY, 8'h01, 8'hff, 1'b1, 1'b1);
        rd(IDX_EXT, 8'h00, 8'h8c, 1'b0, 1'b0);
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00, 8'hff, 1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            wr(IDX_SECS, 8'h00);
            wr(IDX_EXT, rows[i].ext);
            wr(IDX_AMINS, 8'h00);
            wr(IDX_AHOUR, 8'h80);
            wr(IDX_AWD, rows[i].awd);
            for (int k = 6; k >= 0; k--) begin
                wr(4'(k + 1), rows[i].init[k*8 +: 8]);
            end
            rd(IDX_HSEC, 8'h00, 8'hff, 1'b0, 1'b0);
            wr(IDX_FLAG, 8'h00);
            repeat (450) @(posedge clk);
            for (int k = 0; k < 7; k++) begin
                rd(4'(k + 1), rows[i].fin[k*8 +: 8], 8'hff, 1'b0, 1'b0);
            end
            rd(IDX_FLAG, {4'h0, rows[i].af, 3'h0}, 8'h18, 1'b1, !rows[i].af);
            if (rows[i].af) begin
                wr(IDX_FLAG, 8'hff);
                rd(IDX_FLAG, 8'h08, 8'h18, 1'b1, 1'b0);
                wr(IDX_FLAG, 8'h00);
                rd(IDX_FLAG, 8'h00, 8'h18, 1'b1, 1'b1);
            end
        end
        for (int k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            wr(IDX_TPHI, rnd[7:0]);
            rd(IDX_TPHI, rnd[7:0], 8'hff, 1'b0, 1'b0);
            wr(IDX_TPLO, rnd[15:8]);
            rd(IDX_TPLO, rnd[15:8], 8'hff, 1'b0, 1'b0);
        end
        wr(IDX_TPLO, 8'h05);
        wr(IDX_TPHI, 8'hf1);
        wr(IDX_EXT, 8'h10);
        wr(IDX_FLAG, 8'h00);
        repeat (700) @(posedge clk);
        rd(IDX_FLAG, 8'h00, 8'h18, 1'b1, 1'b1);
        repeat (150) @(posedge clk);
        rd(IDX_FLAG, 8'h10, 8'h18, 1'b1, 1'b0);
        wr(IDX_EXT, 8'h00);
        wr(IDX_FLAG, 8'h00);
        rd(IDX_FLAG, 8'h00, 8'h18, 1'b1, 1'b1);
        // other timer sources: 64 Hz and second carry, preset 2
        wr(IDX_TPLO, 8'h02);
        wr(IDX_TPHI, 8'h00);
        for (int s = 1; s < 3; s++) begin
            wr(IDX_EXT, 8'h10 | 8'(s));
            rd(IDX_FLAG, 8'h00, 8'h18, 1'b1, 1'b1);
            repeat (s * 410) @(posedge clk);
            rd(IDX_FLAG, 8'h10, 8'h18, 1'b1, 1'b0);
            wr(IDX_EXT, 8'h00);
            wr(IDX_FLAG, 8'h00);
        end
        rd(IDX_FLAG, 8'h00, 8'h18, 1'b1, 1'b1);
        end_sim();
    end

endmodule // rtcc_core_test

// *** hw/rtcc_core.sv ***
/*
 * rtcc_core: time, calendar, alarm and fixed-cycle timer with AHB-Lite slave.
 * assumes single word transfers from one master; slave answers with no wait.
 */
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
module rtcc_core #(
    parameter int unsigned HS_CYCLES_P  = rtcc_pkg::HS_CYCLES,
    parameter int unsigned T4K_CYCLES_P = rtcc_pkg::T4K_CYCLES,
    parameter int unsigned T64_CYCLES_P = rtcc_pkg::T64_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire rtcc_pkg::rtcc_ahb_req_s ahb_req,
    output logic [31:0]                  hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic                         irq_n
);
    import rtcc_pkg::*;

    typedef struct packed {
        logic [7:0]  hsec;
        logic [7:0]  seconds;
        logic [7:0]  minutes;
        logic [7:0]  hours;
        logic [7:0]  wday;
        logic [7:0]  date;
        logic [7:0]  month;
        logic [7:0]  year;
        logic [7:0]  alarm_mins;
        logic [7:0]  alarm_hours;
        logic [7:0]  alarm_wd;
        logic [7:0]  preset_lo;
        logic [7:0]  preset_hi;
        logic [7:0]  ext;
        logic        alarm_event_flag;
        logic        timer_event_flag;
        logic        match_prev;
        logic [11:0] tmr_cnt;
        logic [31:0] tb_cnt;
        logic [31:0] src_cnt;
        logic        wr_pend;
        logic        wr_map;
        logic [3:0]  wr_idx;
        logic [31:0] rdata;
    } rtcc_state_s;

    rtcc_state_s st_reg;
    rtcc_state_s st_next;
    logic        hs_tick;
    logic        c_sec;
    logic        c_min;
    logic        c_hour;
    logic        c_day;
    logic        c_mon;
    logic        src_tick;
    logic        alarm_match;
    logic        leap;

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic lp);
        case (m)
            8'h02: month_len = lp ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    function automatic logic [7:0] rd_byte(input rtcc_state_s s, input logic [3:0] i);
        if (i == IDX_HSEC) begin
            rd_byte = s.hsec;
        end else if (i == IDX_SECS) begin
            rd_byte = s.seconds;
        end else if (i == IDX_MINS) begin
            rd_byte = s.minutes;
        end else if (i == IDX_HOURS) begin
            rd_byte = s.hours;
        end else if (i == IDX_WDAY) begin
            rd_byte = s.wday;
        end else if (i == IDX_DATE) begin
            rd_byte = s.date;
        end else if (i == IDX_MONTH) begin
            rd_byte = s.month;
        end else if (i == IDX_YEAR) begin
            rd_byte = s.year;
        end else if (i == IDX_AMINS) begin
            rd_byte = s.alarm_mins;
        end else if (i == IDX_AHOUR) begin
            rd_byte = s.alarm_hours;
        end else if (i == IDX_AWD) begin
            rd_byte = s.alarm_wd;
        end else if (i == IDX_TPLO) begin
            rd_byte = s.preset_lo;
        end else if (i == IDX_TPHI) begin
            rd_byte = s.preset_hi;
        end else if (i == IDX_EXT) begin
            rd_byte = s.ext;
        end else begin
            rd_byte = 8'h00;
            rd_byte[FLAG_TF_BIT] = s.timer_event_flag;
            rd_byte[FLAG_AF_BIT] = s.alarm_event_flag;
        end
    endfunction

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic [7:0]  wd;
        logic        wr;
        logic        clr_af;
        logic        clr_tf;
        logic        set_tf;
        logic        te_rise;
        logic [11:0] preset;
        st_next = st_reg;
        wd      = ahb_req.hwdata[7:0];
        wr      = st_reg.wr_pend && st_reg.wr_map;
        clr_af  = 1'b0;
        clr_tf  = 1'b0;
        set_tf  = 1'b0;
        te_rise = 1'b0;
        c_sec   = 1'b0;
        c_min   = 1'b0;
        c_hour  = 1'b0;
        c_day   = 1'b0;
        c_mon   = 1'b0;
        preset  = {st_reg.preset_hi[3:0], st_reg.preset_lo};
        // leap when year value divisible by four
        leap    = ((({st_reg.year[4], 1'b0}) + st_reg.year[1:0]) & 2'b11) == 2'b00;

        hs_tick        = (st_reg.tb_cnt == HS_CYCLES_P - 1);
        st_next.tb_cnt = hs_tick ? 32'h0 : st_reg.tb_cnt + 32'h1;

        if (hs_tick) begin
            c_sec        = (st_reg.hsec == BCD_99);
            st_next.hsec = c_sec ? RST_ZERO : bcd_inc(st_reg.hsec);
        end
        if (c_sec) begin
            c_min           = (st_reg.seconds == BCD_59);
            st_next.seconds = c_min ? RST_ZERO : bcd_inc(st_reg.seconds);
        end
        if (c_min) begin
            c_hour          = (st_reg.minutes == BCD_59);
            st_next.minutes = c_hour ? RST_ZERO : bcd_inc(st_reg.minutes);
        end
        if (c_hour) begin
            c_day         = (st_reg.hours == BCD_23);
            st_next.hours = c_day ? RST_ZERO : bcd_inc(st_reg.hours);
        end
        if (c_day) begin
            st_next.wday = {1'b0, st_reg.wday[5:0], st_reg.wday[6]};
            c_mon        = (st_reg.date == month_len(st_reg.month, leap));
            st_next.date = c_mon ? RST_ONE : bcd_inc(st_reg.date);
        end
        // month wrap; year wrap; calendar span
        if (c_mon) begin
            st_next.month = (st_reg.month == BCD_12) ? RST_ONE : bcd_inc(st_reg.month);
            if (st_reg.month == BCD_12) begin
                st_next.year = (st_reg.year == BCD_99) ? RST_ZERO : bcd_inc(st_reg.year);
            end
        end

        // timer source select
        case (rtcc_tsel_e'(st_reg.ext[EXT_TSEL_LSB +: 2]))
            TSEL_4096: src_tick = (st_reg.src_cnt >= T4K_CYCLES_P - 1);
            TSEL_64:   src_tick = (st_reg.src_cnt >= T64_CYCLES_P - 1);
            TSEL_SEC:  src_tick = c_sec;
            default:   src_tick = c_min;
        endcase
        st_next.src_cnt = src_tick ? 32'h0 : st_reg.src_cnt + 32'h1;

        // ****************************************************
        // register writes (data phase)
        // ****************************************************
        if (wr) begin
            if (st_reg.wr_idx == IDX_SECS) begin
                st_next.seconds = wd & MASK_SECS;
                st_next.hsec    = RST_ZERO;
                st_next.tb_cnt  = 32'h0;
            end else if (st_reg.wr_idx == IDX_MINS) begin
                st_next.minutes = wd & MASK_SECS;
            end else if (st_reg.wr_idx == IDX_HOURS) begin
                st_next.hours = wd & MASK_HOURS;
            end else if (st_reg.wr_idx == IDX_WDAY) begin
                st_next.wday = wd & MASK_WDAY;
            end else if (st_reg.wr_idx == IDX_DATE) begin
                st_next.date = wd & MASK_DATE;
            end else if (st_reg.wr_idx == IDX_MONTH) begin
                st_next.month = wd & MASK_MONTH;
            end else if (st_reg.wr_idx == IDX_YEAR) begin
                st_next.year = wd;
            end else if (st_reg.wr_idx == IDX_AMINS) begin
                st_next.alarm_mins = wd;
            end else if (st_reg.wr_idx == IDX_AHOUR) begin
                st_next.alarm_hours = wd;
            end else if (st_reg.wr_idx == IDX_AWD) begin
                st_next.alarm_wd = wd;
            end else if (st_reg.wr_idx == IDX_TPLO) begin
                st_next.preset_lo = wd;
            end else if (st_reg.wr_idx == IDX_TPHI) begin
                st_next.preset_hi = wd;
            end else if (st_reg.wr_idx == IDX_EXT) begin
                te_rise     = wd[EXT_TMR_EN_BIT] && !st_reg.ext[EXT_TMR_EN_BIT];
                st_next.ext = wd;
            end else if (st_reg.wr_idx == IDX_FLAG) begin
                clr_af = !wd[FLAG_AF_BIT];
                clr_tf = !wd[FLAG_TF_BIT];
            end
        end

        // ****************************************************
        // fixed-cycle timer
        // ****************************************************
        if (te_rise) begin
            st_next.tmr_cnt = preset;
        end else if (st_reg.ext[EXT_TMR_EN_BIT] && src_tick && st_reg.tmr_cnt != 12'h000) begin
            // expiry at 001h, reloads preset in place of 000h
            set_tf          = (st_reg.tmr_cnt == TMR_ONE);
            st_next.tmr_cnt = set_tf ? preset : st_reg.tmr_cnt - 12'h001;
        end

        // ****************************************************
        // alarm compare
        // ****************************************************
        // masked fields always match; date or weekday target
        alarm_match = (st_reg.alarm_mins[ALARM_FIELD_MASK_BIT]
                       || st_reg.alarm_mins[6:0] == st_reg.minutes[6:0])
                   && (st_reg.alarm_hours[ALARM_FIELD_MASK_BIT]
                       || st_reg.alarm_hours[5:0] == st_reg.hours[5:0])
                   && (st_reg.alarm_wd[ALARM_FIELD_MASK_BIT]
                       || (st_reg.ext[EXT_TARGET_BIT] ? st_reg.alarm_wd[5:0] == st_reg.date[5:0]
                                                      : |(st_reg.alarm_wd[6:0] & st_reg.wday[6:0])));
        st_next.match_prev = alarm_match;

        // alarm flag set on new match, set beats clear
        st_next.alarm_event_flag = (st_reg.alarm_event_flag && !clr_af) || (alarm_match && !st_reg.match_prev);
        st_next.timer_event_flag = (st_reg.timer_event_flag && !clr_tf) || set_tf;

        // ****************************************************
        // bus address phase
        // ****************************************************
        st_next.wr_pend = 1'b0;
        if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
            st_next.wr_pend = ahb_req.hwrite;
            st_next.wr_map  = (ahb_req.haddr[31:6] == 26'h0) && (ahb_req.haddr[5:2] <= IDX_FLAG);
            st_next.wr_idx  = ahb_req.haddr[5:2];
            st_next.rdata   = 32'h0;
            if (!ahb_req.hwrite && ahb_req.haddr[31:6] == 26'h0 && ahb_req.haddr[5:2] <= IDX_FLAG) begin
                st_next.rdata = {24'h0, rd_byte(st_reg, ahb_req.haddr[5:2])};
            end
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg         <= '0;
            st_reg.wday    <= RST_ONE;
            st_reg.date    <= RST_ONE;
            st_reg.month   <= RST_ONE;
            st_reg.ext     <= RST_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata    = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // interrupt low while a flag stands
    assign irq_n     = !(st_reg.alarm_event_flag || st_reg.timer_event_flag);

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_hsec_wrap: assert property ((hs_tick && st_reg.hsec == BCD_99 && !st_reg.wr_pend) |=>
        st_reg.hsec == RST_ZERO && st_reg.seconds != $past(st_reg.seconds)) else $error("hundredths wrap");
    a_secs_wrap: assert property ((c_sec && st_reg.seconds == BCD_59 && !st_reg.wr_pend) |=>
        st_reg.seconds == RST_ZERO) else $error("seconds wrap");
    a_mins_wrap: assert property ((c_min && st_reg.minutes == BCD_59 && !st_reg.wr_pend) |=>
        st_reg.minutes == RST_ZERO) else $error("minutes wrap");
    a_hours_wrap: assert property ((c_hour && st_reg.hours == BCD_23 && !st_reg.wr_pend) |=>
        st_reg.hours == RST_ZERO && st_reg.date != $past(st_reg.date)) else $error("hours wrap");
    a_wday_rotate: assert property ((c_day && st_reg.wday == WDAY_LAST && !st_reg.wr_pend) |=>
        st_reg.wday == RST_ONE) else $error("weekday rotation");
    a_feb_leap: assert property ((c_day && st_reg.month == 8'h02 && st_reg.date == 8'h28 && leap
        && !st_reg.wr_pend) |=> st_reg.date == 8'h29 && st_reg.month == 8'h02) else $error("leap day");
    a_month_wrap: assert property ((c_mon && st_reg.month == BCD_12 && !st_reg.wr_pend) |=>
        st_reg.month == RST_ONE && st_reg.date == RST_ONE) else $error("month wrap");
    a_year_wrap: assert property ((c_mon && st_reg.month == BCD_12 && st_reg.year == BCD_99
        && !st_reg.wr_pend) |=> st_reg.year == RST_ZERO) else $error("year wrap");
    a_secs_clear: assert property ((st_reg.wr_pend && st_reg.wr_map && st_reg.wr_idx == IDX_SECS) |=>
        st_reg.hsec == RST_ZERO) else $error("hundredths not cleared");
    a_timer_flag: assert property ((st_reg.tmr_cnt == TMR_ONE && src_tick && st_reg.ext[EXT_TMR_EN_BIT]
        && !st_reg.wr_pend) |=> st_reg.timer_event_flag ##0 !irq_n) else $error("timer flag");
    a_alarm_flag: assert property ((alarm_match && !st_reg.match_prev) |=>
        st_reg.alarm_event_flag && !irq_n) else $error("alarm flag");
    a_flag_hold: assert property ((st_reg.alarm_event_flag && !(st_reg.wr_pend && st_reg.wr_idx == IDX_FLAG))
        |=> st_reg.alarm_event_flag) else $error("flag lost");
    a_unused_zero: assert property (st_reg.seconds[7] == 1'b0 && st_reg.hours[7:6] == 2'b00
        && st_reg.month[7:5] == 3'b000) else $error("unused bit set");
    a_feb_short: assert property ((c_day && st_reg.month == 8'h02 && st_reg.date == 8'h28 && !leap
        && !st_reg.wr_pend) |=> st_reg.date == RST_ONE && st_reg.month == 8'h03) else $error("february wrap");
    a_month_thirty: assert property ((c_day && st_reg.month == 8'h04 && st_reg.date == 8'h30
        && !st_reg.wr_pend) |=> st_reg.date == RST_ONE && st_reg.month == 8'h05) else $error("thirty day wrap");
    a_leap_end: assert property ((c_day && st_reg.month == 8'h02 && st_reg.date == 8'h29 && leap
        && !st_reg.wr_pend) |=> st_reg.date == RST_ONE && st_reg.month == 8'h03) else $error("leap day wrap");
    a_preset_load: assert property ((st_reg.wr_pend && st_reg.wr_map && st_reg.wr_idx == IDX_EXT
        && ahb_req.hwdata[EXT_TMR_EN_BIT] && !st_reg.ext[EXT_TMR_EN_BIT])
        |=> st_reg.tmr_cnt == {st_reg.preset_hi[3:0], st_reg.preset_lo}) else $error("preset not loaded");
    a_af_clear: assert property ((st_reg.wr_pend && st_reg.wr_map && st_reg.wr_idx == IDX_FLAG
        && !ahb_req.hwdata[FLAG_AF_BIT] && !(alarm_match && !st_reg.match_prev))
        |=> !st_reg.alarm_event_flag) else $error("alarm flag not cleared");
    a_tf_clear: assert property ((st_reg.wr_pend && st_reg.wr_map && st_reg.wr_idx == IDX_FLAG
        && !ahb_req.hwdata[FLAG_TF_BIT] && !(src_tick && st_reg.ext[EXT_TMR_EN_BIT] && st_reg.tmr_cnt == TMR_ONE))
        |=> !st_reg.timer_event_flag) else $error("timer flag not cleared");
    a_target_date: assert property ((st_reg.ext[EXT_TARGET_BIT] && !st_reg.alarm_wd[ALARM_FIELD_MASK_BIT]
        && st_reg.alarm_wd[5:0] != st_reg.date[5:0]) |-> !alarm_match) else $error("date target matched");
    a_target_week: assert property ((!st_reg.ext[EXT_TARGET_BIT] && !st_reg.alarm_wd[ALARM_FIELD_MASK_BIT]
        && (st_reg.alarm_wd[6:0] & st_reg.wday[6:0]) == 7'h00) |-> !alarm_match) else $error("weekday target matched");
    a_mask_mins: assert property ((!st_reg.alarm_mins[ALARM_FIELD_MASK_BIT]
        && st_reg.alarm_mins[6:0] != st_reg.minutes[6:0]) |-> !alarm_match) else $error("minute mismatch matched");
    a_mask_match: assert property ((st_reg.alarm_hours[ALARM_FIELD_MASK_BIT]
        && st_reg.alarm_wd[ALARM_FIELD_MASK_BIT] && st_reg.alarm_mins[6:0] == st_reg.minutes[6:0])
        |-> alarm_match) else $error("masked fields blocked");
    a_ext_reset: assert property ($fell(srst) |-> st_reg.ext == RST_ZERO) else $error("extension not cleared");

endmodule // rtcc_core

// *** hw/rtcc_pkg.sv ***
/*
 * rtcc_pkg: constants, types and register map of the real time clock core.
 * assumes a 250 MHz clk and a byte-wide register file behind AHB-Lite.
 */
package rtcc_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned HS_PERIOD_NS   = 10_000_000;
    localparam int unsigned HS_CYCLES      = HS_PERIOD_NS / (CLK_PERIOD_PS / 1000);
    localparam int unsigned T4K_PERIOD_PS  = 244_140_625;
    localparam int unsigned T4K_CYCLES     = T4K_PERIOD_PS / CLK_PERIOD_PS;
    localparam int unsigned T64_PERIOD_NS  = 15_625_000;
    localparam int unsigned T64_CYCLES     = T64_PERIOD_NS / (CLK_PERIOD_PS / 1000);

    // ********************************************************
    // register indices (byte address = 4 * index)
    // ********************************************************
    localparam logic [3:0] IDX_HSEC  = 4'h0;
    localparam logic [3:0] IDX_SECS  = 4'h1;
    localparam logic [3:0] IDX_MINS  = 4'h2;
    localparam logic [3:0] IDX_HOURS = 4'h3;
    localparam logic [3:0] IDX_WDAY  = 4'h4;
    localparam logic [3:0] IDX_DATE  = 4'h5;
    localparam logic [3:0] IDX_MONTH = 4'h6;
    localparam logic [3:0] IDX_YEAR  = 4'h7;
    localparam logic [3:0] IDX_AMINS = 4'h8;
    localparam logic [3:0] IDX_AHOUR = 4'h9;
    localparam logic [3:0] IDX_AWD   = 4'ha;
    localparam logic [3:0] IDX_TPLO  = 4'hb;
    localparam logic [3:0] IDX_TPHI  = 4'hc;
    localparam logic [3:0] IDX_EXT   = 4'hd;
    localparam logic [3:0] IDX_FLAG  = 4'he;

    // ********************************************************
    // field positions and masks
    // ********************************************************
    localparam int unsigned ALARM_FIELD_MASK_BIT = 7;
    localparam int unsigned EXT_TEST_BIT         = 7;
    localparam int unsigned EXT_TARGET_BIT       = 6;
    localparam int unsigned EXT_TMR_EN_BIT       = 4;
    localparam int unsigned EXT_TSEL_LSB         = 0;
    localparam int unsigned FLAG_TF_BIT          = 4;
    localparam int unsigned FLAG_AF_BIT          = 3;
    localparam logic [7:0]  MASK_SECS  = 8'h7f;
    localparam logic [7:0]  MASK_HOURS = 8'h3f;
    localparam logic [7:0]  MASK_WDAY  = 8'h7f;
    localparam logic [7:0]  MASK_DATE  = 8'h3f;
    localparam logic [7:0]  MASK_MONTH = 8'h1f;
    localparam logic [7:0]  BCD_59     = 8'h59;
    localparam logic [7:0]  BCD_99     = 8'h99;
    localparam logic [7:0]  BCD_23     = 8'h23;
    localparam logic [7:0]  BCD_12     = 8'h12;
    localparam logic [7:0]  WDAY_LAST  = 8'h40;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0]  RST_ZERO   = 8'h00;
    localparam logic [7:0]  RST_ONE    = 8'h01;
    localparam logic [11:0] TMR_ONE    = 12'h001;

    typedef enum logic [1:0] {
        TSEL_4096 = 2'b00,
        TSEL_64   = 2'b01,
        TSEL_SEC  = 2'b10,
        TSEL_MIN  = 2'b11
    } rtcc_tsel_e;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } rtcc_ahb_req_s;

endpackage
